/* File: hdl/cbl_consts.svh */
/*
  Constants for the cold boot loader: mode codes, field positions, timing.
  Assumes inclusion by bare name from the design file.
*/
`ifndef CBL_CONSTS_SVH
`define CBL_CONSTS_SVH
`define CBL_MODE_RUN 2'h0
`define CBL_MODE_ASYNC 2'h1
`define CBL_MODE_SYNC 2'h2
`define CBL_MODE_SLAVE 2'h3
`define CBL_ADDR_SPACE_BIT 15
`define CBL_CLK_HZ 20000000
`define CBL_BAUD_BPS 2400
`define CBL_BIT_CYC (`CBL_CLK_HZ / `CBL_BAUD_BPS)
`define CBL_HALF_CYC (`CBL_BIT_CYC / 2)
`define CBL_BITS_PER_BYTE 4'h8
`define CBL_FIFO_DEPTH 16
`endif

/* File: hdl/cbl_pkg.sv */
/*
  Types shared by the cold boot loader.
  Assumes cbl_consts.svh is on the include path.
*/
package cbl_pkg;
  typedef struct packed {
    logic io_space;
    logic [14:0] addr;
    logic [7:0] data;
  } cbl_write_t;
  typedef enum logic [1:0] {
    CBL_RUN,
    CBL_ASYNC,
    CBL_SYNC,
    CBL_SLAVE
  } cbl_mode_t;
endpackage : cbl_pkg

/* File: hdl/cbl_loader.sv */
/*
  Cold boot loader: boot mode sampling, three byte receivers, a byte FIFO,
  triplet assembly and write issue.
  Assumes all pins synchronous to clk_sys; memory write accepted each strobe.
*/
`timescale 1ns/1ps
`include "cbl_consts.svh"
// Contract
// - Sample both mode pins when reset ends; they pick the startup procedure.
// - Both pins low: no download, start fetching at address zero.
// - After reset, address zero maps to chip select zero with output enable zero; code asserts both only in run state, not during download.
// - Other three settings receive a byte stream and store a boot program.
// - Stream arrives by async serial 2400 bps, clocked sync serial, or slave port.
// - Stream is three-byte groups; exactly one byte write per complete group.
// - Address top bit selects I/O space; low fifteen bits address first 32K.
// - Any I/O-space write ends the download; execution begins at zero.
// - I/O writes may remap memory to zero; sender should map RAM there.

module cbl_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;
  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= AW'(wr_q + 1'b1);
      end
      if (pop) begin
        rd_q <= AW'(rd_q + 1'b1);
      end
      cnt_q <= (AW+1)'(cnt_q + push - pop);
    end
  end
endmodule : cbl_fifo

module cbl_loader #(
  parameter int BIT_CYC = `CBL_BIT_CYC
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic boot_mode_pin_0,
  input wire logic boot_mode_pin_1,
  input wire logic async_rxd,
  input wire logic sync_sclk,
  input wire logic sync_rxd,
  input wire logic slave_wr_strobe,
  input wire logic [7:0] slave_wr_data,
  output logic slave_busy,
  output logic boot_active,
  output logic cpu_run,
  output logic [14:0] wr_addr,
  output logic [7:0] wr_data,
  output logic mem_wr,
  output logic io_wr,
  output logic memory_chip_select_zero_n,
  output logic memory_output_enable_zero_n
);
  typedef enum logic [1:0] {ST_INIT, ST_LOAD, ST_RUN} cbl_state_t;
  cbl_state_t st_q;
  cbl_pkg::cbl_mode_t mode_q;
  logic [1:0] byte_idx_q;
  logic [7:0] hi_q;
  logic [7:0] lo_q;
  logic [7:0] rx_byte;
  logic rx_valid;
  logic fifo_ready;
  logic f_valid;
  logic f_ready;
  logic [7:0] f_data;
  cbl_pkg::cbl_write_t wr_req;
  logic [15:0] bit_cnt_q;
  logic [3:0] a_bits_q;
  logic [7:0] a_sh_q;
  logic a_busy_q;
  logic a_done_q;
  logic sclk_q;
  logic [3:0] s_bits_q;
  logic [7:0] s_sh_q;
  logic s_done_q;
  logic sl_done_q;
  logic [7:0] sl_q;
  // --------------------------------------------------------------------
  // Mode sampling
  // --------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= ST_INIT;
      mode_q <= cbl_pkg::CBL_RUN;
    end else begin
      case (st_q)
        ST_INIT: begin
          mode_q <= cbl_pkg::cbl_mode_t'({boot_mode_pin_1, boot_mode_pin_0});
          if ({boot_mode_pin_1, boot_mode_pin_0} == `CBL_MODE_RUN) begin
            st_q <= ST_RUN;
          end else begin
            st_q <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          if (f_valid && byte_idx_q == 2'h2 && hi_q[7]) begin
            st_q <= ST_RUN;
          end
        end
        ST_RUN: st_q <= ST_RUN;
        default: st_q <= ST_INIT;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Async receiver, 8N1 at 2400 bps
  // --------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      bit_cnt_q <= 16'h0000;
      a_bits_q <= 4'h0;
      a_sh_q <= 8'h00;
      a_busy_q <= 1'b0;
      a_done_q <= 1'b0;
    end else begin
      a_done_q <= 1'b0;
      if (st_q == ST_LOAD && mode_q == cbl_pkg::CBL_ASYNC) begin
        if (!a_busy_q) begin
          if (!async_rxd) begin
            a_busy_q <= 1'b1;
            bit_cnt_q <= 16'(BIT_CYC / 2);
            a_bits_q <= 4'h0;
          end
        end else if (bit_cnt_q != 16'h0000) begin
          bit_cnt_q <= 16'(bit_cnt_q - 1'b1);
        end else begin
          bit_cnt_q <= 16'(BIT_CYC - 1);
          a_bits_q <= 4'(a_bits_q + 1'b1);
          if (a_bits_q == 4'h0) begin
            a_busy_q <= ~async_rxd;
          end else if (a_bits_q <= `CBL_BITS_PER_BYTE) begin
            a_sh_q <= {async_rxd, a_sh_q[7:1]};
          end else begin
            a_busy_q <= 1'b0;
            a_done_q <= async_rxd;
          end
        end
      end
    end
  end

  // --------------------------------------------------------------------
  // Sync receiver, external clock, LSB first on rising edge
  // --------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sclk_q <= 1'b0;
      s_bits_q <= 4'h0;
      s_sh_q <= 8'h00;
      s_done_q <= 1'b0;
    end else begin
      sclk_q <= sync_sclk;
      s_done_q <= 1'b0;
      if (st_q == ST_LOAD && mode_q == cbl_pkg::CBL_SYNC && sync_sclk && !sclk_q) begin
        s_sh_q <= {sync_rxd, s_sh_q[7:1]};
        if (s_bits_q == 4'(`CBL_BITS_PER_BYTE - 1)) begin
          s_bits_q <= 4'h0;
          s_done_q <= 1'b1;
        end else begin
          s_bits_q <= 4'(s_bits_q + 1'b1);
        end
      end
    end
  end

  // --------------------------------------------------------------------
  // Slave port byte capture
  // --------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sl_q <= 8'h00;
      sl_done_q <= 1'b0;
      slave_busy <= 1'b0;
    end else begin
      sl_done_q <= st_q == ST_LOAD && mode_q == cbl_pkg::CBL_SLAVE && slave_wr_strobe
                   && fifo_ready;
      sl_q <= slave_wr_data;
      slave_busy <= !fifo_ready || st_q != ST_LOAD;
    end
  end
  always_comb begin
    rx_valid = 1'b0;
    rx_byte = 8'h00;
    case (mode_q)
      cbl_pkg::CBL_ASYNC: begin
        rx_valid = a_done_q;
        rx_byte = a_sh_q;
      end
      cbl_pkg::CBL_SYNC: begin
        rx_valid = s_done_q;
        rx_byte = s_sh_q;
      end
      cbl_pkg::CBL_SLAVE: begin
        rx_valid = sl_done_q;
        rx_byte = sl_q;
      end
      default: rx_valid = 1'b0;
    endcase
  end
  cbl_fifo #(.WIDTH(8), .DEPTH(`CBL_FIFO_DEPTH)) u_fifo (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .in_valid(rx_valid),
    .in_ready(fifo_ready),
    .in_data(rx_byte),
    .out_valid(f_valid),
    .out_ready(f_ready),
    .out_data(f_data)
  );
  // --------------------------------------------------------------------
  // Triplet assembly and write issue
  // --------------------------------------------------------------------
  assign f_ready = (st_q == ST_LOAD);
  assign wr_req = '{io_space: hi_q[7], addr: {hi_q[6:0], lo_q}, data: f_data};
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      byte_idx_q <= 2'h0;
      hi_q <= 8'h00;
      lo_q <= 8'h00;
      wr_addr <= 15'h0000;
      wr_data <= 8'h00;
      mem_wr <= 1'b0;
      io_wr <= 1'b0;
    end else begin
      mem_wr <= 1'b0;
      io_wr <= 1'b0;
      if (f_valid && f_ready) begin
        case (byte_idx_q)
          2'h0: hi_q <= f_data;
          2'h1: lo_q <= f_data;
          default: begin
            wr_addr <= wr_req.addr;
            wr_data <= wr_req.data;
            mem_wr <= !wr_req.io_space;
            io_wr <= wr_req.io_space;
          end
        endcase
        byte_idx_q <= (byte_idx_q == 2'h2) ? 2'h0 : 2'(byte_idx_q + 1'b1);
      end
    end
  end
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      boot_active <= 1'b0;
      cpu_run <= 1'b0;
      memory_chip_select_zero_n <= 1'b1;
      memory_output_enable_zero_n <= 1'b1;
    end else begin
      boot_active <= (st_q == ST_LOAD);
      cpu_run <= (st_q == ST_RUN);
      memory_chip_select_zero_n <= !(st_q == ST_RUN);
      memory_output_enable_zero_n <= !(st_q == ST_RUN);
    end
  end
  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  property p_run_direct;
    @(posedge clk_sys) disable iff (!arst_n)
      (st_q == ST_INIT && !boot_mode_pin_0 && !boot_mode_pin_1) |=> ##1 cpu_run;
  endproperty
  a_run_direct: assert property (p_run_direct) else $error("no direct run");
  property p_load_mode;
    @(posedge clk_sys) disable iff (!arst_n)
      (st_q == ST_INIT && (boot_mode_pin_0 || boot_mode_pin_1)) |=> ##1 boot_active;
  endproperty
  a_load_mode: assert property (p_load_mode) else $error("no download");
  property p_mode_kept;
    @(posedge clk_sys) disable iff (!arst_n) (st_q != ST_INIT) |=> $stable(mode_q);
  endproperty
  a_mode_kept: assert property (p_mode_kept) else $error("mode changed");
  property p_one_write;
    @(posedge clk_sys) disable iff (!arst_n)
      (mem_wr || io_wr) |-> !(mem_wr && io_wr) && $past(f_valid && f_ready && byte_idx_q == 2'h2);
  endproperty
  a_one_write: assert property (p_one_write) else $error("double write");
  property p_io_end;
    @(posedge clk_sys) disable iff (!arst_n) io_wr |-> ##1 cpu_run;
  endproperty
  a_io_end: assert property (p_io_end) else $error("io write kept boot");
  property p_space;
    @(posedge clk_sys) disable iff (!arst_n)
      (f_valid && f_ready && byte_idx_q == 2'h2) |=> (io_wr == $past(hi_q[7]));
  endproperty
  a_space: assert property (p_space) else $error("wrong space");
  property p_addr;
    @(posedge clk_sys) disable iff (!arst_n)
      (f_valid && f_ready && byte_idx_q == 2'h2) |=> wr_addr == $past({hi_q[6:0], lo_q});
  endproperty
  a_addr: assert property (p_addr) else $error("bad address order");
  property p_cs0;
    @(posedge clk_sys) disable iff (!arst_n) cpu_run |-> !memory_chip_select_zero_n;
  endproperty
  a_cs0: assert property (p_cs0) else $error("cs0 not selected");
  property p_quiet;
    @(posedge clk_sys) disable iff (!arst_n) cpu_run |-> !boot_active && slave_busy;
  endproperty
  a_quiet: assert property (p_quiet) else $error("boot while running");
  c_mem: cover property (@(posedge clk_sys) disable iff (!arst_n) mem_wr);
  c_io: cover property (@(posedge clk_sys) disable iff (!arst_n) io_wr);
  c_full: cover property (@(posedge clk_sys) disable iff (!arst_n) !fifo_ready);
endmodule : cbl_loader

/* File: bench/cbl_host.sv */
/*
  Boot stream sender: async serial, clocked serial, slave port.
  Assumes inputs sampled on clk_sys rising edge; drives on falling edge.
*/
`timescale 1ns/1ps
module cbl_host #(
  parameter int BIT_CYC = 16
) (
  input wire logic clk_sys,
  input wire logic slave_busy,
  output logic async_rxd,
  output logic sync_sclk,
  output logic sync_rxd,
  output logic slave_wr_strobe,
  output logic [7:0] slave_wr_data
);
  int stall_total;
  initial begin
    stall_total = 0;
    async_rxd = 1'b1;
    sync_sclk = 1'b0;
    sync_rxd = 1'b0;
    slave_wr_strobe = 1'b0;
    slave_wr_data = 8'h00;
  end
  // Mode 0 strobes without waiting, to be refused
  task automatic send(input logic [1:0] m, input logic [7:0] b);
    int n;
    @(negedge clk_sys);
    if (m == 2'h1) begin
      for (int i = 0; i < 10; i++) begin
        async_rxd = (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : b[i-1];
        repeat (BIT_CYC) @(negedge clk_sys);
      end
    end else if (m == 2'h2) begin
      for (int i = 0; i < 8; i++) begin
        sync_rxd = b[i];
        repeat (2) @(negedge clk_sys);
        sync_sclk = 1'b1;
        repeat (2) @(negedge clk_sys);
        sync_sclk = 1'b0;
      end
      sync_rxd = ~b[7];
    end else begin
      n = 0;
      while (m == 2'h3 && slave_busy !== 1'b0 && n < 100) begin
        @(negedge clk_sys);
        n++;
      end
      if (n == 100) stall_total++;
      slave_wr_strobe = 1'b1;
      slave_wr_data = b;
      @(negedge clk_sys);
      slave_wr_strobe = 1'b0;
      slave_wr_data = ~b;
    end
  endtask : send
endmodule : cbl_host

/* File: bench/cbl_loader_test.sv */
/*
  Self-checking bench for the cold boot loader with a queue model.
  Assumes cbl_host as sender and memory that takes every write.
*/
`timescale 1ns/1ps
module cbl_loader_test;
  localparam int BIT_CYC = 16;
  logic clk_sys, arst_n, pin0, pin1, async_rxd, sync_sclk, sync_rxd;
  logic slave_wr_strobe, slave_busy, boot_active, cpu_run, mem_wr, io_wr, cs_n, oe_n;
  logic [7:0] slave_wr_data, wr_data;
  logic [14:0] wr_addr;
  logic [31:0] rnd_q;
  logic stop_q;
  cbl_pkg::cbl_write_t exp_q[$];
  cbl_pkg::cbl_write_t w;
  int err_total, checked;
  cbl_loader #(.BIT_CYC(BIT_CYC)) u_dut (.clk_sys(clk_sys), .arst_n(arst_n),
    .boot_mode_pin_0(pin0), .boot_mode_pin_1(pin1), .async_rxd(async_rxd),
    .sync_sclk(sync_sclk), .sync_rxd(sync_rxd), .slave_wr_strobe(slave_wr_strobe),
    .slave_wr_data(slave_wr_data), .slave_busy(slave_busy), .boot_active(boot_active),
    .cpu_run(cpu_run), .wr_addr(wr_addr), .wr_data(wr_data), .mem_wr(mem_wr),
    .io_wr(io_wr), .memory_chip_select_zero_n(cs_n), .memory_output_enable_zero_n(oe_n));
  cbl_host #(.BIT_CYC(BIT_CYC)) u_host (.clk_sys(clk_sys), .slave_busy(slave_busy),
    .async_rxd(async_rxd), .sync_sclk(sync_sclk), .sync_rxd(sync_rxd),
    .slave_wr_strobe(slave_wr_strobe), .slave_wr_data(slave_wr_data));
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  task automatic fail(input string s);
    err_total++;
    $display("wrong value at %0t: %s", $time, s);
  endtask : fail
  task automatic check_flag(input logic got, input logic exp, input string s);
    checked++;
    if (got !== exp) fail(s);
  endtask : check_flag
  task automatic check_write(input cbl_pkg::cbl_write_t got, input cbl_pkg::cbl_write_t exp);
    checked++;
    if (got !== exp) fail("write content");
  endtask : check_write
  task automatic summarize;
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : summarize
  // Write pulses span one full cycle, so each is seen at one falling edge
  always @(negedge clk_sys) begin
    if (mem_wr === 1'b1 || io_wr === 1'b1) begin
      if (exp_q.size() == 0) fail("unexpected write");
      else begin
        w = exp_q.pop_front();
        check_flag(mem_wr, ~w.io_space, "memory strobe");
        check_write({io_wr, wr_addr, wr_data}, w);
      end
    end
  end
  task automatic start(input logic [1:0] m);
    @(negedge clk_sys);
    arst_n = 1'b0;
    {pin1, pin0} = m;
    repeat (10) @(negedge clk_sys);
    check_flag(cs_n, 1'b1, "select in reset");
    arst_n = 1'b1;
    stop_q = (m == 2'h0);
    repeat (3) @(negedge clk_sys);
    check_flag(cpu_run, m == 2'h0, "run flag");
    check_flag(boot_active, m != 2'h0, "boot flag");
  endtask : start
  task automatic triplet(input logic [1:0] m, input logic io);
    cbl_pkg::cbl_write_t t;
    logic [1:0] mm;
    rnd_q = xs(rnd_q);
    t = {io, rnd_q[14:0], rnd_q[23:16]};
    if (!stop_q) exp_q.push_back(t);
    // Loader stopped: slave strobes go out unpaced and must be refused
    mm = (stop_q && m == 2'h3) ? 2'h0 : m;
    stop_q = stop_q | io;
    u_host.send(mm, {t.io_space, t.addr[14:8]});
    u_host.send(mm, t.addr[7:0]);
    u_host.send(mm, t.data);
  endtask : triplet
  task automatic settle;
    int n;
    n = 0;
    while (exp_q.size() != 0 && n < 200) begin
      @(negedge clk_sys);
      n++;
    end
    if (exp_q.size() != 0) fail("write missing");
    repeat (4) @(negedge clk_sys);
  endtask : settle
  initial begin
    logic [1:0] m;
    arst_n = 1'b0;
    pin0 = 1'b0;
    pin1 = 1'b0;
    rnd_q = 32'h0000_004c;
    stop_q = 1'b0;
    err_total = 0;
    checked = 0;
    start(2'h0);
    check_flag(cs_n, 1'b0, "select in run");
    check_flag(oe_n, 1'b0, "enable in run");
    check_flag(slave_busy, 1'b1, "busy in run");
    triplet(2'h0, 1'b0);
    settle;
    $display("test mode 0 done");
    for (int k = 0; k < 3; k++) begin
      m = 2'h3 - k[1:0];
      start(m);
      check_flag(cs_n, 1'b1, "select while loading");
      repeat ((m == 2'h3) ? 20 : 2) triplet(m, 1'b0);
      triplet(m, 1'b1);
      triplet(m, 1'b0);
      settle;
      check_flag(cpu_run, 1'b1, "run after io write");
      check_flag(boot_active, 1'b0, "boot after io write");
      check_flag(cs_n, 1'b0, "select after boot");
      $display("test mode %0d done", m);
    end
    if (u_host.stall_total != 0) fail("sender stalled on busy");
    summarize;
  end
endmodule : cbl_loader_test
